// [hdl/tx_output_source_ctrl.sv]
// transmitter output routing and channel status / user data source control
`timescale 1ns/1ps
`include "tx_source_defines.svh"

module tx_output_source_ctrl #(
    parameter int DEPTH     = `CU_BUFFER_BYTES,
    parameter int HOST_LEAD = `CU_HOST_LEAD_BYTES,
    parameter int AW        = $clog2(DEPTH)
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_reg_wr,
    input  wire logic          i_reg_rd,
    input  wire logic [7:0]    i_reg_addr,
    input  wire logic [7:0]    i_reg_wdata,
    output logic      [7:0]    o_reg_rdata,
    input  wire logic          i_encoder_out,
    input  wire logic [3:0]    i_rx_line,
    input  wire logic          i_host_validity,
    input  wire logic          i_rx_validity,
    input  wire logic          i_host_buf_wr,
    input  wire logic [AW-1:0] i_host_buf_idx,
    input  wire logic [7:0]    i_host_buf_data,
    input  wire logic          i_rx_buf_wr,
    input  wire logic [AW-1:0] i_rx_buf_idx,
    input  wire logic [7:0]    i_rx_buf_data,
    input  wire logic          i_block_start,
    input  wire logic [AW-1:0] i_ta_idx,
    output logic      [7:0]    o_ta_data,
    output logic               o_line_driver,
    output logic               o_cmos_out,
    output logic               o_tx_validity
);

    logic [7:0] route_ff;
    logic [7:0] nxt_route;
    logic [2:0] source_ff;
    logic [2:0] nxt_source;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [3:0] rx_meta_ff;
    logic [3:0] rx_sync_ff;
    logic       line_ff;
    logic       nxt_line;
    logic       cmos_ff;
    logic       nxt_cmos;
    logic       bypass;
    logic [1:0] bypass_receiver_sel;
    logic       line_driver_source_sel;
    logic       cmos_out_source_sel;
    logic       buffer_transfer_disable;
    logic       validity_source_sel;
    tx_source_pkg::cu_source_e cu_buffer_source_sel;
    logic [3:0] nxt_rx_meta;
    logic [3:0] nxt_rx_sync;

    // address decode shared by the write and read paths
    function automatic logic is_route_addr(input logic [7:0] addr);
        is_route_addr = (addr == `ROUTE_CTRL_OFFSET);
    endfunction

    function automatic logic is_source_addr(input logic [7:0] addr);
        is_source_addr = (addr == `SOURCE_CTRL_OFFSET);
    endfunction

    // two-bit selector to one receiver line
    function automatic logic pick_receiver(input logic [1:0] sel,
                                           input logic [3:0] lines);
        case (sel)
            2'b00:   pick_receiver = lines[0];
            2'b01:   pick_receiver = lines[1];
            2'b10:   pick_receiver = lines[2];
            2'b11:   pick_receiver = lines[3];
            default: pick_receiver = 1'b0;
        endcase
    endfunction

    // encoder or bypass, shared by the line driver and cmos paths
    function automatic logic pick_source(input logic sel,
                                         input logic bypass_bit,
                                         input logic encoder_bit);
        pick_source = sel ? bypass_bit : encoder_bit;
    endfunction

    always_comb begin
        nxt_route = route_ff;
        if (i_reg_wr && is_route_addr(i_reg_addr)) begin
            // low three bits are not stored and read back as zero
            nxt_route = {i_reg_wdata[7:3], 3'b000};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            route_ff <= `ROUTE_CTRL_RESET;
        end else begin
            route_ff <= nxt_route;
        end
    end

    always_comb begin
        nxt_source = source_ff;
        if (i_reg_wr && is_source_addr(i_reg_addr)) begin
            nxt_source = i_reg_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            source_ff <= 3'(`SOURCE_CTRL_RESET);
        end else begin
            source_ff <= nxt_source;
        end
    end

    // read-back, held until the next read strobe
    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd) begin
            if (is_route_addr(i_reg_addr)) begin
                nxt_rdata = route_ff;
            end else if (is_source_addr(i_reg_addr)) begin
                nxt_rdata = {5'b0_0000, source_ff};
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign bypass_receiver_sel =
        route_ff[`BYPASS_SEL_MSB:`BYPASS_SEL_LSB];
    assign cmos_out_source_sel     = route_ff[`CMOS_SEL_BIT];
    assign line_driver_source_sel  = route_ff[`LINE_SEL_BIT];
    assign buffer_transfer_disable = route_ff[`XFER_DISABLE_BIT];
    assign validity_source_sel     = source_ff[`VALIDITY_SEL_BIT];
    assign cu_buffer_source_sel    = tx_source_pkg::cu_source_e'(
        source_ff[`CU_SEL_MSB:`CU_SEL_LSB]);

    // receiver lines are asynchronous pins
    always_comb begin
        nxt_rx_meta = i_rx_line;
        nxt_rx_sync = rx_meta_ff;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_meta_ff <= 4'h0;
            rx_sync_ff <= 4'h0;
        end else begin
            rx_meta_ff <= nxt_rx_meta;
            rx_sync_ff <= nxt_rx_sync;
        end
    end

    always_comb begin
        bypass = pick_receiver(bypass_receiver_sel, rx_sync_ff);
    end

    // registered outputs so a select change cannot glitch the pins
    always_comb begin
        nxt_line = pick_source(line_driver_source_sel, bypass,
                               i_encoder_out);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            line_ff <= 1'b0;
        end else begin
            line_ff <= nxt_line;
        end
    end

    always_comb begin
        nxt_cmos = pick_source(cmos_out_source_sel, bypass,
                               i_encoder_out);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cmos_ff <= 1'b0;
        end else begin
            cmos_ff <= nxt_cmos;
        end
    end

    assign o_line_driver = line_ff;
    assign o_cmos_out    = cmos_ff;
    assign o_reg_rdata   = rdata_ff;

    assign o_tx_validity = validity_source_sel ? i_rx_validity
                                               : i_host_validity;

    cu_buffer_loader #(
        .DEPTH     (DEPTH),
        .HOST_LEAD (HOST_LEAD),
        .AW        (AW)
    ) u_cu_buffer_loader (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_src          (cu_buffer_source_sel),
        .i_xfer_disable (buffer_transfer_disable),
        .i_host_wr      (i_host_buf_wr),
        .i_host_idx     (i_host_buf_idx),
        .i_host_data    (i_host_buf_data),
        .i_rx_wr        (i_rx_buf_wr),
        .i_rx_idx       (i_rx_buf_idx),
        .i_rx_data      (i_rx_buf_data),
        .i_block_start  (i_block_start),
        .i_ta_idx       (i_ta_idx),
        .o_ta_data      (o_ta_data)
    );

endmodule // tx_output_source_ctrl

// [hdl/tx_source_defines.svh]
// register offsets, field positions and reset values of the source control
`ifndef TX_SOURCE_DEFINES_SVH
`define TX_SOURCE_DEFINES_SVH

`define ROUTE_CTRL_OFFSET    8'h08
`define SOURCE_CTRL_OFFSET   8'h09
`define ROUTE_CTRL_RESET     8'h00
`define SOURCE_CTRL_RESET    8'h00

`define BYPASS_SEL_MSB       7
`define BYPASS_SEL_LSB       6
`define CMOS_SEL_BIT         5
`define LINE_SEL_BIT         4
`define XFER_DISABLE_BIT     3
`define VALIDITY_SEL_BIT     2
`define CU_SEL_MSB           1
`define CU_SEL_LSB           0

`define CU_BUFFER_BYTES      24
`define CU_HOST_LEAD_BYTES   10

`endif

// [hdl/tx_source_pkg.sv]
// types shared by the transmitter source selection logic
package tx_source_pkg;

    typedef enum logic [1:0] {
        CU_SRC_NONE  = 2'b00,
        CU_SRC_HOST  = 2'b01,
        CU_SRC_RX    = 2'b10,
        CU_SRC_SPLIT = 2'b11
    } cu_source_e;

    typedef logic [7:0] byte_t;

endpackage

// [hdl/cu_buffer_loader.sv]
// channel status / user data buffers: user access and transmitter access
`timescale 1ns/1ps
`include "tx_source_defines.svh"

module cu_buffer_loader #(
    parameter int DEPTH     = `CU_BUFFER_BYTES,
    parameter int HOST_LEAD = `CU_HOST_LEAD_BYTES,
    parameter int AW        = $clog2(DEPTH)
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire tx_source_pkg::cu_source_e i_src,
    input  wire logic                     i_xfer_disable,
    input  wire logic                     i_host_wr,
    input  wire logic [AW-1:0]            i_host_idx,
    input  wire logic [7:0]               i_host_data,
    input  wire logic                     i_rx_wr,
    input  wire logic [AW-1:0]            i_rx_idx,
    input  wire logic [7:0]               i_rx_data,
    input  wire logic                     i_block_start,
    input  wire logic [AW-1:0]            i_ta_idx,
    output logic [7:0]                    o_ta_data
);

    localparam logic [AW-1:0] LEAD = AW'(HOST_LEAD);

    tx_source_pkg::byte_t ua_ff  [DEPTH];
    tx_source_pkg::byte_t ta_ff  [DEPTH];
    tx_source_pkg::byte_t nxt_ua [DEPTH];
    tx_source_pkg::byte_t nxt_ta [DEPTH];
    logic [7:0]           ta_data_ff;
    logic [7:0]           nxt_ta_data;

    // which writer may load a given byte under the current source
    function automatic logic may_load(input tx_source_pkg::cu_source_e src,
                                      input logic from_host,
                                      input logic [AW-1:0] idx);
        case (src)
            tx_source_pkg::CU_SRC_HOST:  may_load = from_host;
            tx_source_pkg::CU_SRC_RX:    may_load = !from_host;
            tx_source_pkg::CU_SRC_SPLIT: may_load = from_host ? (idx < LEAD)
                                                             : (idx >= LEAD);
            default:                     may_load = 1'b0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_byte
            always_comb begin
                nxt_ua[g] = ua_ff[g];
                // host or receiver load as may_load allows; in split, host lead and receiver rest
                if (i_host_wr && i_host_idx == AW'(g)
                        && may_load(i_src, 1'b1, i_host_idx)) begin
                    nxt_ua[g] = i_host_data;
                end else if (i_rx_wr && i_rx_idx == AW'(g)
                        && may_load(i_src, 1'b0, i_rx_idx)) begin
                    nxt_ua[g] = i_rx_data;
                end
                nxt_ta[g] = ta_ff[g];
                if (i_block_start && !i_xfer_disable) begin
                    nxt_ta[g] = ua_ff[g];
                end
            end

            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    ua_ff[g] <= 8'h00;
                    ta_ff[g] <= 8'h00;
                end else begin
                    ua_ff[g] <= nxt_ua[g];
                    ta_ff[g] <= nxt_ta[g];
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_ta_data = (int'(i_ta_idx) < DEPTH) ? ta_ff[i_ta_idx] : 8'h00;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ta_data_ff <= 8'h00;
        end else begin
            ta_data_ff <= nxt_ta_data;
        end
    end

    assign o_ta_data = ta_data_ff;

endmodule // cu_buffer_loader

// [verification/tx_source_properties.sv]
// assertions on the transmitter source control ports
`timescale 1ns/1ps
module tx_source_properties #(
    parameter int AW = 5
) (
    input wire logic          i_clk,
    input wire logic          i_rst,
    input wire logic          i_reg_wr,
    input wire logic [7:0]    i_reg_addr,
    input wire logic [7:0]    i_reg_wdata,
    input wire logic          i_encoder_out,
    input wire logic [3:0]    i_rx_line,
    input wire logic          i_host_validity,
    input wire logic          i_rx_validity,
    input wire logic [AW-1:0] i_ta_idx,
    input wire logic [7:0]    o_ta_data,
    input wire logic          o_line_driver,
    input wire logic          o_cmos_out,
    input wire logic          o_tx_validity
);
    logic [7:0] route_ff;
    logic       vsel_ff;
    logic [3:0] rx1_ff;
    logic [3:0] rx2_ff;
    // shadow of the selections and of the pin synchroniser
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            route_ff <= 8'h00;
            vsel_ff  <= 1'b0;
            rx1_ff   <= 4'h0;
            rx2_ff   <= 4'h0;
        end else begin
            rx1_ff <= i_rx_line;
            rx2_ff <= rx1_ff;
            if (i_reg_wr && i_reg_addr == 8'h08)
                route_ff <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == 8'h09)
                vsel_ff <= i_reg_wdata[2];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_line_encoder: assert property (
        !route_ff[4] |=> o_line_driver == $past(i_encoder_out))
        else $error("line driver not from encoder");
    a_line_bypass: assert property (
        route_ff[4] |=> o_line_driver == $past(rx2_ff[route_ff[7:6]]))
        else $error("line driver not from bypass");
    a_cmos_encoder: assert property (
        !route_ff[5] |=> o_cmos_out == $past(i_encoder_out))
        else $error("cmos output not from encoder");
    a_cmos_bypass: assert property (
        route_ff[5] |=> o_cmos_out == $past(rx2_ff[route_ff[7:6]]))
        else $error("cmos output not from bypass");
    a_valid_host: assert property (
        !vsel_ff |-> o_tx_validity == i_host_validity)
        else $error("validity not from host bit");
    a_valid_rx: assert property (
        vsel_ff |-> o_tx_validity == i_rx_validity)
        else $error("validity not from receiver");
    a_ta_frozen: assert property (
        route_ff[3] && $past(route_ff[3]) && $stable(i_ta_idx)
        |=> $stable(o_ta_data))
        else $error("transmitter buffer changed while disabled");
    a_select_delay: assert property (
        $rose(route_ff[4]) |-> o_line_driver == $past(i_encoder_out))
        else $error("line select applied too early");
endmodule // tx_source_properties

bind tx_output_source_ctrl tx_source_properties #(.AW(AW)) chk_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_encoder_out(i_encoder_out), .i_rx_line(i_rx_line),
    .i_host_validity(i_host_validity), .i_rx_validity(i_rx_validity),
    .i_ta_idx(i_ta_idx), .o_ta_data(o_ta_data),
    .o_line_driver(o_line_driver), .o_cmos_out(o_cmos_out),
    .o_tx_validity(o_tx_validity));

// [verification/host_port_model.sv]
// host control port model: single byte register writes and reads
`timescale 1ns/1ps
module host_port_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(posedge i_clk);
        #1 d = i_rdata;
    endtask
endmodule // host_port_model

// [verification/testbench.sv]
// self-checking bench for the transmitter source control
`timescale 1ns/1ps
module testbench;
    logic       clk, rst, wr, rd, enc, hv, rv, hbw, rbw, bs, ld, co, tv;
    logic [7:0] addr, wdata, rdata, hbd, rbd, tad, v;
    logic [4:0] hbi, rbi, tai;
    logic [3:0] rx;
    int         err_total, tests_run;

    host_port_model host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    tx_output_source_ctrl dut (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_encoder_out(enc), .i_rx_line(rx),
        .i_host_validity(hv), .i_rx_validity(rv), .i_host_buf_wr(hbw),
        .i_host_buf_idx(hbi), .i_host_buf_data(hbd), .i_rx_buf_wr(rbw),
        .i_rx_buf_idx(rbi), .i_rx_buf_data(rbd), .i_block_start(bs),
        .i_ta_idx(tai), .o_ta_data(tad), .o_line_driver(ld),
        .o_cmos_out(co), .o_tx_validity(tv));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_regs();
        host.rd(8'h08, v);
        chk(v, 8'h00);
        host.rd(8'h09, v);
        chk(v, 8'h00);
        host.wr(8'h08, 8'hff);
        host.wr(8'h09, 8'hff);
        host.rd(8'h08, v);
        chk(v, 8'hf8);
        host.rd(8'h09, v);
        chk(v, 8'h07);
        host.rd(8'h0a, v);
        chk(v, 8'h00);
        host.wr(8'h08, 8'h00);
        host.wr(8'h09, 8'h00);
    endtask
    task automatic t_route();
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h08, {2'(s), 6'h30});
            rx <= 4'h1 << s;
            cyc(5);
            chk(ld, 1);
            chk(co, 1);
            rx <= ~(4'h1 << s);
            cyc(5);
            chk(ld, 0);
            chk(co, 0);
        end
        host.wr(8'h08, 8'h10);
        rx <= 4'h1;
        cyc(5);
        chk(ld, 1);
        chk(co, 0);
        host.wr(8'h08, 8'h20);
        cyc(2);
        chk(ld, 0);
        chk(co, 1);
        @(posedge clk);
        enc <= 1'b1;
        rx  <= 4'h0;
        cyc(5);
        chk(ld, 1);
        chk(co, 0);
        host.wr(8'h08, 8'h00);
        cyc(2);
        chk(ld, 1);
        chk(co, 1);
    endtask
    task automatic t_valid();
        for (int s = 0; s < 2; s++) begin
            host.wr(8'h09, {5'h0, 1'(s), 2'b00});
            @(posedge clk);
            hv <= 1'b1;
            rv <= 1'b0;
            #1 chk(tv, 1 - s);
            @(posedge clk);
            hv <= 1'b0;
            rv <= 1'b1;
            #1 chk(tv, s);
        end
    endtask
    task automatic bput(input logic h, input logic [4:0] i,
                        input logic [7:0] d);
        @(posedge clk);
        hbw <= h;
        rbw <= !h;
        hbi <= i;
        rbi <= i;
        hbd <= d;
        rbd <= d;
        @(posedge clk);
        hbw <= 1'b0;
        rbw <= 1'b0;
    endtask
    task automatic tcopy(input logic [4:0] i, input logic [7:0] e);
        @(posedge clk);
        bs <= 1'b1;
        tai <= i;
        @(posedge clk);
        bs <= 1'b0;
        cyc(2);
        chk(tad, e);
    endtask
    task automatic t_buf();
        logic [7:0] lo, hi;
        lo = 0;
        hi = 0;
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h09, 8'(s));
            bput(1, 5'd9, 8'ha0 + 8'(s));
            bput(0, 5'd9, 8'h50 + 8'(s));
            bput(1, 5'd10, 8'hb0 + 8'(s));
            bput(0, 5'd10, 8'h60 + 8'(s));
            if (s == 1 || s == 3) lo = 8'ha0 + 8'(s);
            if (s == 2) lo = 8'h52;
            if (s == 1) hi = 8'hb1;
            if (s >= 2) hi = 8'h60 + 8'(s);
            tcopy(5'd9, lo);
            tcopy(5'd10, hi);
        end
        host.wr(8'h09, 8'h01);
        host.wr(8'h08, 8'h08);
        bput(1, 5'd9, 8'hee);
        tcopy(5'd9, lo);
        host.wr(8'h08, 8'h00);
        tcopy(5'd9, 8'hee);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
    initial begin
        {err_total, tests_run} = '0;
        {rst, enc, hv, rv, hbw, rbw, bs} = 7'h40;
        {rx, hbi, rbi, tai, hbd, rbd} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_route();
        t_valid();
        t_buf();
        end_sim();
    end
endmodule // testbench
